// file: tcp_pkg.sv
// shared constants and carriers of the thermocouple channel parameter block
package tcp_pkg;
  // register addresses inside one channel's 64-word set
  localparam logic [5:0]  A_RAW      = 6'h00;  // raw converter value
  localparam logic [5:0]  A_DIAG     = 6'h06;  // diagnostic / status byte
  localparam logic [5:0]  A_HWOFF    = 6'h11;  // hardware offset compensation
  localparam logic [5:0]  A_HWGAIN   = 6'h12;  // hardware gain compensation
  localparam logic [5:0]  A_MKOFF    = 6'h13;  // maker straight-line offset
  localparam logic [5:0]  A_MKGAIN   = 6'h14;  // maker straight-line gain
  localparam logic [5:0]  A_RJGAIN   = 6'h15;  // ref junction gain compensation
  localparam logic [5:0]  A_UNLOCK   = 6'h1F;  // code-word register
  localparam logic [5:0]  A_FEAT     = 6'h20;  // operating features
  localparam logic [5:0]  A_USOFF    = 6'h21;  // user straight-line offset
  localparam logic [5:0]  A_USGAIN   = 6'h22;  // user straight-line gain
  localparam logic [5:0]  A_FILT     = 6'h25;  // filter setting
  localparam logic [5:0]  A_PROT_LO  = 6'h10;  // first write-protected word
  localparam logic [5:0]  A_PROT_HI  = 6'h2F;  // last write-protected word
  // code word and reset values
  localparam logic [15:0] UNLOCK_CODE = 16'h1235;
  localparam logic [15:0] FEAT_RST    = 16'h1006;
  localparam logic [15:0] MKOFF_RST   = 16'h0000;
  localparam logic [15:0] MKGAIN_RST  = 16'h00A0;
  localparam logic [15:0] FILT_RST    = 16'h0000;
  localparam logic [15:0] HWOFF_RST   = 16'h0000;
  localparam logic [15:0] HWGAIN_RST  = 16'h4000;
  localparam logic [15:0] RJGAIN_RST  = 16'h0100;
  localparam logic [15:0] USOFF_RST   = 16'h0000;
  localparam logic [15:0] USGAIN_RST  = 16'h0100;
  localparam logic [15:0] ZERO16      = 16'h0000;
  // feature bit positions
  localparam int F_USER   = 0;   // user scaling on
  localparam int F_MAKER  = 1;   // maker scaling on
  localparam int F_WDOG   = 2;   // watchdog on
  localparam int F_SGNMAG = 3;   // sign-magnitude output
  localparam int F_STLOW  = 4;   // status in low three bits
  localparam int F_FILT   = 5;   // filter setting applied
  localparam int F_NOBRK  = 6;   // broken-wire current off
  localparam int F_NOREF  = 8;   // ref junction compensation off
  localparam int F_NOLOW  = 10;  // lower limit check skipped
  localparam int F_TYPE   = 12;  // sensor type field, bits 15..12
  localparam logic [3:0]  TYPE_LAST_TC  = 4'h9;  // highest thermocouple code
  localparam logic [3:0]  TYPE_UV_FIRST = 4'hD;  // lowest microvolt code
  // control and status byte bits
  localparam int CB_REG   = 7;
  localparam int CB_WR    = 6;
  localparam int SB_ERR   = 6;
  localparam int SB_OVER  = 1;
  localparam int SB_UNDER = 0;
  // converter code points and fixed-point weights
  localparam logic [15:0] RAW_MID   = 16'h8000;
  localparam logic [15:0] RAW_MIN   = 16'h0000;
  localparam logic [15:0] RAW_MAX   = 16'hFFFF;
  localparam int          LINE_SHIFT = 8;   // straight-line gain weight 2^-8
  localparam int          HW_SHIFT   = 14;  // hardware gain weight 2^-14
  localparam logic signed [31:0] OUT_MAX = 32'sh0000_7FFF;
  localparam logic signed [31:0] OUT_MIN = -32'sh0000_8000;
  // request from the coupler: control byte plus output data word
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [15:0] data;
  } tcp_xreq_t;
  // answer to the coupler: status byte plus input data word
  typedef struct packed {
    logic [7:0]  status;
    logic [15:0] data;
  } tcp_xrsp_t;
  // store request towards the nonvolatile parameter memory
  typedef struct packed {
    logic        wr;
    logic [5:0]  addr;
    logic [15:0] data;
  } tcp_nvw_t;
endpackage : tcp_pkg

// file: tcp_channel.sv
// Behaviour
// R1: user area writable only after code 0x1235
// R2: other code-word value turns protection on
// R3: code-word reads 0x1235 unlocked, else zero
// R4: user parameters kept in nonvolatile storage
// R5: raw value offset-binary, midpoint is zero
// R6: diagnostic low byte status, high reserved
// R7: hardware offset and gain compensate converter
// R8: maker line offset 0, gain 0x00A0
// R9: feature bit 0 enables user line
// R10: feature bit 1 enables maker line
// R11: feature bit 2 enables watchdog
// R12: feature bit 3 selects sign-magnitude
// R13: feature bit 4 puts status in bits
// R14: feature bit 5 applies filter setting
// R15: feature bit 6 cuts broken-wire current
// R16: feature bit 8 disables junction compensation
// R17: feature bit 10 skips lower limit
// R18: feature bits 15..12 select sensor type
// R19: maker line only gives 0.1 degC digits
// R20: no scaling gives 1/16 degC digits
// R21: control byte register mode, write, address
// R22: status byte error, over, under bits
// R23: locked writes leave parameters unchanged
`timescale 1ns/1ns
`default_nettype none
module tcp_channel (
  input  wire logic             sys_clk_i,       // module clock
  input  wire logic             reset_i,         // power-on reset
  input  wire logic             xchg_i,          // coupler exchange strobe
  input  wire tcp_pkg::tcp_xreq_t xreq_i,        // control byte and data out
  input  wire logic             adc_valid_i,     // new conversion pulse
  input  wire logic [15:0]      adc_data_i,      // offset-binary result
  input  wire logic             nv_load_i,       // restore pulse from storage
  input  wire tcp_pkg::tcp_nvw_t nv_load_data_i, // restored word
  output tcp_pkg::tcp_xrsp_t    xrsp_o,          // status byte and data in
  output tcp_pkg::tcp_nvw_t     nv_store_o,      // store request
  output logic                  watchdog_en_o,   // watchdog enable
  output logic                  break_cur_off_o, // broken-wire current off
  output logic                  ref_comp_off_o,  // junction compensation off
  output logic [15:0]           ref_gain_o,      // junction gain word
  output logic [15:0]           filt_const_o     // filter setting in force
);
  import tcp_pkg::*;

  // whole module state
  typedef struct packed {
    logic        lock;      // user area write protection
    logic [15:0] feat;      // operating features
    logic [15:0] hw_off;    // hardware offset
    logic [15:0] hw_gain;   // hardware gain
    logic [15:0] mk_off;    // maker offset
    logic [15:0] mk_gain;   // maker gain
    logic [15:0] rj_gain;   // junction gain
    logic [15:0] us_off;    // user offset
    logic [15:0] us_gain;   // user gain
    logic [15:0] filt;      // filter setting
    logic [15:0] filt_act;  // filter setting in force
    logic [15:0] raw;       // last raw conversion
    logic [15:0] val;       // formatted process value
    logic        over;      // over range
    logic        under;     // under range
    logic        err;       // general error
    tcp_xrsp_t   rsp;       // answer to coupler
    tcp_nvw_t    nvw;       // store request
  } tcp_state_t;

  tcp_state_t  st_r;        // registered state
  tcp_state_t  st_nxt;      // next state

  // decoded request
  logic        reg_mode;    // register access asked
  logic        wr_req;      // register write asked
  logic [5:0]  addr;        // register address
  logic        prot_hit;    // address in protected area
  logic        wr_ok;       // write allowed to store
  logic [15:0] rd_word;     // read multiplexer
  logic [7:0]  stat_byte;   // process status byte

  // conversion arithmetic
  logic signed [31:0] s_raw;    // signed converter value
  logic signed [31:0] s_hw;     // after hardware compensation
  logic signed [31:0] s_mk;     // after maker line
  logic signed [31:0] s_us;     // after user line
  logic [15:0]        v_sat;    // saturated two's complement
  logic [15:0]        v_fmt;    // after representation options
  logic               ovr_c;    // over range now
  logic               und_c;    // under range now
  logic               type_bad; // unused sensor code

  // request decode
  always_comb begin
    reg_mode = xreq_i.ctrl[CB_REG];                                  // [R21]
    wr_req   = reg_mode && xreq_i.ctrl[CB_WR];                       // [R21]
    addr     = xreq_i.ctrl[5:0];                                     // [R21]
    prot_hit = (addr >= A_PROT_LO) && (addr <= A_PROT_HI) && (addr != A_UNLOCK);
    wr_ok    = xchg_i && wr_req && prot_hit && !st_r.lock;           // [R1] [R23]
  end

  // status byte for process exchange
  always_comb begin
    stat_byte           = 8'h00;                                     // bit 7 and reserved clear [R22]
    stat_byte[SB_ERR]   = st_r.err;                                  // [R22]
    stat_byte[SB_OVER]  = st_r.over;                                 // [R22]
    stat_byte[SB_UNDER] = st_r.under;                                // [R22]
  end

  // register read multiplexer
  always_comb begin
    case (addr)
      A_RAW:    rd_word = st_r.raw;                                  // [R5]
      A_DIAG:   rd_word = {8'h00, stat_byte};                        // [R6]
      A_HWOFF:  rd_word = st_r.hw_off;
      A_HWGAIN: rd_word = st_r.hw_gain;
      A_MKOFF:  rd_word = st_r.mk_off;
      A_MKGAIN: rd_word = st_r.mk_gain;
      A_RJGAIN: rd_word = st_r.rj_gain;
      A_UNLOCK: rd_word = st_r.lock ? ZERO16 : UNLOCK_CODE;          // [R3]
      A_FEAT:   rd_word = st_r.feat;
      A_USOFF:  rd_word = st_r.us_off;
      A_USGAIN: rd_word = st_r.us_gain;
      A_FILT:   rd_word = st_r.filt;
      default:  rd_word = ZERO16;                                    // unused words read zero
    endcase
  end

  // conversion chain from raw code to formatted value
  always_comb begin
    // flip the top bit: midpoint code becomes zero
    s_raw = 32'(signed'(adc_data_i ^ RAW_MID));                      // [R5]
    s_hw  = ((s_raw + 32'(signed'(st_r.hw_off))) * 32'(signed'(st_r.hw_gain))) >>> HW_SHIFT; // [R7]
    // maker line, default gain turns 1/16 degC into 0.1 degC
    if (st_r.feat[F_MAKER]) begin                                    // [R10] [R19]
      s_mk = ((s_hw * 32'(signed'(st_r.mk_gain))) >>> LINE_SHIFT) + 32'(signed'(st_r.mk_off)); // [R8]
    end else begin
      s_mk = s_hw;                                                   // raw digits [R20]
    end
    // user line on top of the maker line
    if (st_r.feat[F_USER]) begin                                     // [R9]
      s_us = ((s_mk * 32'(signed'(st_r.us_gain))) >>> LINE_SHIFT) + 32'(signed'(st_r.us_off)); // [R9]
    end else begin
      s_us = s_mk;
    end
    // sensor codes 1010..1100 select nothing
    type_bad = (st_r.feat[15:F_TYPE] > TYPE_LAST_TC) &&
               (st_r.feat[15:F_TYPE] < TYPE_UV_FIRST);               // [R18]
    // range limits, lower check may be switched off
    ovr_c = (s_us > OUT_MAX) || (adc_data_i == RAW_MAX);
    und_c = !st_r.feat[F_NOLOW] &&
            ((s_us < OUT_MIN) || (adc_data_i == RAW_MIN));           // [R17]
    // saturate into 16 bits
    if (ovr_c) begin
      v_sat = OUT_MAX[15:0];
    end else if (s_us < OUT_MIN) begin
      v_sat = OUT_MIN[15:0];
    end else begin
      v_sat = s_us[15:0];
    end
    // sign-magnitude: minus one shows as 0x8001
    if (st_r.feat[F_SGNMAG] && v_sat[15]) begin                      // [R12]
      v_fmt = {1'b1, 15'(-v_sat[14:0])};                             // [R12]
    end else begin
      v_fmt = v_sat;
    end
    // status in low bits: value in 15..3, bits 2..1 zero
    if (st_r.feat[F_STLOW]) begin                                    // [R13]
      v_fmt = {v_fmt[15:3], 2'b00, (ovr_c || und_c)};                // [R13]
    end
  end

  // next state
  always_comb begin
    st_nxt         = st_r;
    st_nxt.nvw.wr  = 1'b0;                                           // store request is a pulse
    st_nxt.filt_act = st_r.feat[F_FILT] ? st_r.filt : FILT_RST;      // [R14]
    // restore from storage after power-up
    if (nv_load_i) begin                                             // [R4]
      case (nv_load_data_i.addr)
        A_HWOFF:  st_nxt.hw_off  = nv_load_data_i.data;
        A_HWGAIN: st_nxt.hw_gain = nv_load_data_i.data;
        A_MKOFF:  st_nxt.mk_off  = nv_load_data_i.data;
        A_MKGAIN: st_nxt.mk_gain = nv_load_data_i.data;
        A_RJGAIN: st_nxt.rj_gain = nv_load_data_i.data;
        A_FEAT:   st_nxt.feat    = nv_load_data_i.data;
        A_USOFF:  st_nxt.us_off  = nv_load_data_i.data;
        A_USGAIN: st_nxt.us_gain = nv_load_data_i.data;
        A_FILT:   st_nxt.filt    = nv_load_data_i.data;
        default:  st_nxt.filt    = st_nxt.filt;                      // other words not stored
      endcase
    end
    // new conversion result
    if (adc_valid_i) begin
      st_nxt.raw   = adc_data_i;                                     // [R5]
      st_nxt.val   = v_fmt;
      st_nxt.over  = ovr_c;                                          // [R22]
      st_nxt.under = und_c;                                          // [R22]
      st_nxt.err   = ovr_c || und_c || type_bad;                     // [R22] [R18]
    end
    // coupler exchange
    if (xchg_i) begin
      if (reg_mode) begin
        // acknowledge: register flag and address, write flag dropped
        st_nxt.rsp.status = {1'b1, 1'b0, addr};                      // [R21]
        st_nxt.rsp.data   = wr_req ? ZERO16 : rd_word;               // [R21]
      end else begin
        st_nxt.rsp.status = stat_byte;                               // [R22]
        st_nxt.rsp.data   = st_r.val;
      end
      // code word decides protection
      if (wr_req && (addr == A_UNLOCK)) begin
        st_nxt.lock = (xreq_i.data != UNLOCK_CODE);                  // [R1] [R2]
      end
      // protected parameter writes
      if (wr_ok) begin                                               // [R1] [R23]
        case (addr)
          A_HWOFF:  st_nxt.hw_off  = xreq_i.data;                    // [R7]
          A_HWGAIN: st_nxt.hw_gain = xreq_i.data;                    // [R7]
          A_MKOFF:  st_nxt.mk_off  = xreq_i.data;                    // [R8]
          A_MKGAIN: st_nxt.mk_gain = xreq_i.data;                    // [R8]
          A_RJGAIN: st_nxt.rj_gain = xreq_i.data;
          A_FEAT:   st_nxt.feat    = xreq_i.data;                    // [R18]
          A_USOFF:  st_nxt.us_off  = xreq_i.data;                    // [R9]
          A_USGAIN: st_nxt.us_gain = xreq_i.data;                    // [R9]
          A_FILT:   st_nxt.filt    = xreq_i.data;                    // [R14]
          default:  st_nxt.filt    = st_nxt.filt;                    // reserved words ignore writes
        endcase
        // every accepted write is passed to the storage
        st_nxt.nvw.wr   = 1'b1;                                      // [R4]
        st_nxt.nvw.addr = addr;
        st_nxt.nvw.data = xreq_i.data;
      end
    end
  end

  // state register with delivery defaults
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r          <= '0;
      st_r.lock     <= 1'b1;                                         // protected after power-up [R2]
      st_r.feat     <= FEAT_RST;                                     // [R10] [R11] [R9] [R16] [R17]
      st_r.hw_off   <= HWOFF_RST;
      st_r.hw_gain  <= HWGAIN_RST;
      st_r.mk_off   <= MKOFF_RST;                                    // [R8]
      st_r.mk_gain  <= MKGAIN_RST;                                   // [R8]
      st_r.rj_gain  <= RJGAIN_RST;
      st_r.us_off   <= USOFF_RST;
      st_r.us_gain  <= USGAIN_RST;
      st_r.filt     <= FILT_RST;
      st_r.filt_act <= FILT_RST;
      st_r.raw      <= RAW_MID;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs taken from state flops
  assign xrsp_o          = st_r.rsp;
  assign nv_store_o      = st_r.nvw;
  assign watchdog_en_o   = st_r.feat[F_WDOG];                        // [R11]
  assign break_cur_off_o = st_r.feat[F_NOBRK];                       // [R15]
  assign ref_comp_off_o  = st_r.feat[F_NOREF];                       // [R16]
  assign ref_gain_o      = st_r.rj_gain;
  assign filt_const_o    = st_r.filt_act;                            // [R14]

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  AST_UNLOCK: assert property (xchg_i && wr_req && addr == A_UNLOCK && xreq_i.data == UNLOCK_CODE
                               |=> !st_r.lock) // [R1]
    else $error("code word did not unlock");
  AST_LOCK: assert property (xchg_i && wr_req && addr == A_UNLOCK && xreq_i.data != UNLOCK_CODE
                             |=> st_r.lock) // [R2]
    else $error("other code word did not lock");
  AST_CW_READ: assert property (xchg_i && reg_mode && !wr_req && addr == A_UNLOCK
                                |=> xrsp_o.data == ($past(st_r.lock) ? ZERO16 : UNLOCK_CODE)) // [R3]
    else $error("code word read wrong");
  AST_PROTECT: assert property (xchg_i && wr_req && addr == A_FEAT && st_r.lock && !nv_load_i
                                |=> $stable(st_r.feat) && !nv_store_o.wr) // [R23]
    else $error("locked write changed features");
  AST_STORE: assert property (xchg_i && wr_req && addr == A_USOFF && !st_r.lock
                              |=> nv_store_o.wr && nv_store_o.addr == A_USOFF ##1 !nv_store_o.wr) // [R4]
    else $error("store request missing");
  AST_DIAG: assert property (xchg_i && reg_mode && !wr_req && addr == A_DIAG
                             |=> xrsp_o.data[15:8] == 8'h00 && xrsp_o.data[7] == 1'b0) // [R6]
    else $error("diagnostic high byte not zero");
  AST_ACK: assert property (xchg_i && reg_mode
                            |=> xrsp_o.status == {2'b10, $past(xreq_i.ctrl[5:0])}) // [R21]
    else $error("register ack wrong");
  AST_STATUS: assert property (xchg_i && !reg_mode
                               |=> xrsp_o.status[7] == 1'b0 && xrsp_o.status[5:2] == 4'h0) // [R22]
    else $error("status byte reserved bits set");
  AST_STLOW: assert property (adc_valid_i && st_r.feat[F_STLOW]
                              |=> st_r.val[2:1] == 2'b00 && st_r.val[0] == (st_r.over || st_r.under)) // [R13]
    else $error("status-in-low-bits format wrong");
  AST_SGNMAG: assert property (adc_valid_i && st_r.feat[F_SGNMAG] && !st_r.feat[F_STLOW] && v_sat == 16'hFFFF
                               |=> st_r.val == 16'h8001) // [R12]
    else $error("sign-magnitude minus one wrong");
  AST_FILT: assert property (!st_r.feat[F_FILT] |=> filt_const_o == FILT_RST) // [R14]
    else $error("filter setting applied while off");

endmodule : tcp_channel
`default_nettype wire

// file: tcp_coupler_model.sv
`timescale 1ns/1ns
`default_nettype none
// coupler side: one exchange per bench request, answer captured
module tcp_coupler_model (
  input  wire logic               sys_clk_i, // module clock
  input  wire logic               reset_i,   // async reset
  input  wire logic               req_i,     // bench request level
  input  wire logic [3:0]         delay_i,   // idle cycles before issue
  input  wire logic [7:0]         ctrl_i,    // control byte
  input  wire logic [15:0]        data_i,    // output word
  input  wire tcp_pkg::tcp_xrsp_t xrsp_i,    // device answer
  output logic                    xchg_o,    // exchange strobe
  output tcp_pkg::tcp_xreq_t      xreq_o,    // control byte and word
  output logic                    done_o,    // answer captured
  output tcp_pkg::tcp_xrsp_t      rsp_o      // captured answer
);
  import tcp_pkg::*;
  logic [1:0] st_r;  // idle, taken, answer, hold
  logic [3:0] cnt_r; // idle cycles counted before issue
  // exchange sequencer
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r   <= 2'h0;
      cnt_r  <= 4'h0;
      xchg_o <= 1'b0;
      xreq_o <= '0;
      done_o <= 1'b0;
      rsp_o  <= '0;
    end else begin
      case (st_r)
        2'h0: if (req_i && cnt_r == delay_i) begin
          xchg_o <= 1'b1;
          xreq_o <= {ctrl_i, data_i};
          st_r   <= 2'h1;
        end else if (req_i) begin
          cnt_r <= cnt_r + 4'h1;
        end
        2'h1: begin
          xchg_o <= 1'b0;
          xreq_o <= ~xreq_o; // released lines do not hold
          st_r   <= 2'h2;
        end
        2'h2: begin
          rsp_o  <= xrsp_i;
          done_o <= 1'b1;
          st_r   <= 2'h3;
        end
        default: if (!req_i) begin
          done_o <= 1'b0;
          cnt_r  <= 4'h0;
          st_r   <= 2'h0;
        end
      endcase
    end
  end
endmodule : tcp_coupler_model
`default_nettype wire

// file: thermocouple_channel_params_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module thermocouple_channel_params_tb_top;
  import tcp_pkg::*;
  logic        sys_clk_i, reset_i, req, adc_valid, nv_load, xchg, done, wdog, brk, refoff;
  logic [3:0]  dly;
  logic [7:0]  ctrl;
  logic [15:0] wdata, adc_data, rgain, filt;
  tcp_nvw_t    nv_ld, nv_st, last_st;
  tcp_xreq_t   xreq;
  tcp_xrsp_t   xrsp, rsp;
  int          n_fail, checks_done, cyc, n_store;
  logic [15:0] fv [4] = '{16'h0050, 16'h00A0, 16'h0140, 16'h0280}; // filter values
  tcp_channel DUT (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .xchg_i(xchg), .xreq_i(xreq),
    .adc_valid_i(adc_valid), .adc_data_i(adc_data), .nv_load_i(nv_load), .nv_load_data_i(nv_ld),
    .xrsp_o(xrsp), .nv_store_o(nv_st), .watchdog_en_o(wdog), .break_cur_off_o(brk),
    .ref_comp_off_o(refoff), .ref_gain_o(rgain), .filt_const_o(filt));
  tcp_coupler_model u_cpl (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .req_i(req), .delay_i(dly),
    .ctrl_i(ctrl), .data_i(wdata), .xrsp_i(xrsp), .xchg_o(xchg), .xreq_o(xreq), .done_o(done), .rsp_o(rsp));
  // clock
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // store pulse monitor and hang guard
  always @(posedge sys_clk_i) begin
    cyc++;
    if (nv_st.wr === 1'b1) begin
      n_store++;
      last_st = nv_st;
    end
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // one exchange through the coupler model
  task automatic xfer(input logic [7:0] c, input logic [15:0] d);
    int i;
    i = 0;
    @(posedge sys_clk_i);
    req   <= 1'b1;
    ctrl  <= c;
    wdata <= d;
    @(posedge sys_clk_i);
    while (done !== 1'b1 && i < 60) begin
      @(posedge sys_clk_i);
      i++;
    end
    if (i == 60) n_fail++;
    req <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    xfer({2'b11, a}, d);
    check("ack status", {8'h00, rsp.status}, {8'h00, 2'b10, a});
    check("ack data", rsp.data, 16'h0000);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    xfer({2'b10, a}, 16'h0000);
    check("rd status", {8'h00, rsp.status}, {8'h00, 2'b10, a});
    check("rd data", rsp.data, e);
  endtask : rd
  task automatic proc(input logic [7:0] s, input logic [15:0] d);
    xfer(8'h00, 16'h0000);
    check("status", {8'h00, rsp.status}, {8'h00, s});
    check("value", rsp.data, d);
  endtask : proc
  task automatic conv(input logic [15:0] v);
    @(posedge sys_clk_i);
    adc_valid <= 1'b1;
    adc_data  <= v;
    @(posedge sys_clk_i);
    adc_valid <= 1'b0;
    adc_data  <= ~v;
  endtask : conv
  // main sequence
  initial begin
    {req, adc_valid, nv_load, dly, ctrl, wdata, adc_data, nv_ld} = '0;
    reset_i = 1'b1;
    repeat (8) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    @(posedge sys_clk_i);
    check("wdog", {15'h0, wdog}, 16'h0001);
    check("brk", {15'h0, brk}, 16'h0000);
    check("refoff", {15'h0, refoff}, 16'h0000);
    check("filt", filt, 16'h0000);
    check("rgain rst", rgain, 16'h0100);
    rd(A_FEAT, 16'h1006);
    rd(A_MKGAIN, 16'h00A0);
    rd(A_MKOFF, 16'h0000);
    rd(A_FILT, 16'h0000);
    rd(A_UNLOCK, 16'h0000);
    rd(A_RAW, 16'h8000);
    rd(6'h3F, 16'h0000);
    wr(A_FEAT, 16'h1166);
    rd(A_FEAT, 16'h1006);
    check("no store", n_store[15:0], 16'h0000);
    wr(A_UNLOCK, UNLOCK_CODE);
    rd(A_UNLOCK, 16'h1235);
    wr(A_FEAT, 16'h1166);
    check("store addr", {10'h0, last_st.addr}, {10'h0, A_FEAT});
    check("store data", last_st.data, 16'h1166);
    check("brk on", {15'h0, brk}, 16'h0001);
    check("refoff on", {15'h0, refoff}, 16'h0001);
    wr(A_RJGAIN, 16'h0123);
    check("rgain", rgain, 16'h0123);
    dly <= 4'h3;
    for (int k = 0; k < 4; k++) begin
      wr(A_FILT, fv[k]);
      check("filt set", filt, fv[k]);
    end
    dly <= 4'h0;
    wr(A_FEAT, 16'h1000);
    check("wdog off", {15'h0, wdog}, 16'h0000);
    check("filt off", filt, 16'h0000);
    conv(16'h8010);
    proc(8'h00, 16'h0010);
    rd(A_RAW, 16'h8010);
    wr(A_HWOFF, 16'h0010);
    conv(16'h8000);
    proc(8'h00, 16'h0010);
    wr(A_HWGAIN, 16'h2000);
    conv(16'h8000);
    proc(8'h00, 16'h0008);
    wr(A_HWOFF, 16'h0000);
    wr(A_HWGAIN, 16'h4000);
    wr(A_FEAT, 16'h1008);
    conv(16'h7FFF);
    proc(8'h00, 16'h8001);
    wr(A_FEAT, 16'h1010);
    conv(16'h7FFF);
    proc(8'h00, 16'hFFF8);
    conv(16'hFFFF);
    proc(8'h42, 16'h7FF9);
    rd(A_DIAG, 16'h0042);
    wr(A_FEAT, 16'h1000);
    conv(16'h0000);
    proc(8'h41, 16'h8000);
    wr(A_FEAT, 16'h1400);
    conv(16'h0000);
    proc(8'h00, 16'h8000);
    wr(A_FEAT, 16'h1002);
    conv(16'h8100);
    proc(8'h00, 16'h00A0);
    wr(A_USGAIN, 16'h0200);
    wr(A_USOFF, 16'h0005);
    wr(A_FEAT, 16'h1003);
    conv(16'h8100);
    proc(8'h00, 16'h0145);
    for (int t = 0; t < 16; t++) begin
      wr(A_FEAT, {t[3:0], 12'h000});
      conv(16'h8100);
      proc((t >= 10 && t <= 12) ? 8'h40 : 8'h00, 16'h0100);
    end
    wr(A_UNLOCK, 16'h0000);
    rd(A_UNLOCK, 16'h0000);
    wr(A_USOFF, 16'h0007);
    rd(A_USOFF, 16'h0005);
    @(posedge sys_clk_i);
    nv_load <= 1'b1;
    nv_ld   <= {1'b0, A_USOFF, 16'h0033};
    @(posedge sys_clk_i);
    nv_load <= 1'b0;
    rd(A_USOFF, 16'h0033);
    end_sim();
  end
endmodule : thermocouple_channel_params_tb_top
`default_nettype wire
